// ===== src/gcs_pkg.sv
// gcs_pkg: constants for the global control and status register pair.
// assumes a byte-wide configuration space reached by 16-bit memory addresses.
package gcs_pkg;

	// ----------------------------------------
	// address map
	// ----------------------------------------
	localparam logic [15:0] GCS_CFG_BASE = 16'h8000;
	localparam logic [15:0] GCS_STATUS_ADDR = 16'h800e;
	localparam logic [15:0] GCS_CONTROL_ADDR = 16'h800f;
	localparam int GCS_CFG_SEL_BIT = 15;

	// ----------------------------------------
	// control fields
	// ----------------------------------------
	localparam int GCS_CTL_RX_EN = 7;
	localparam int GCS_CTL_TX_EN = 6;
	localparam int GCS_CTL_LBL_REV = 3;
	localparam logic [7:0] GCS_CTL_RESET = 8'h00;

	// ----------------------------------------
	// status fields
	// ----------------------------------------
	localparam int GCS_ST_READY = 7;
	localparam int GCS_ST_ACTIVE = 6;
	localparam int GCS_ST_SAFE = 5;
	localparam int GCS_ST_RAM = 4;
	localparam int GCS_ST_EEPROM_WRITE_IN_PROGRESS = 3;
	localparam int GCS_ST_LOAD = 2;
	localparam logic [7:0] GCS_ST_RESET = 8'h00;
	localparam logic [7:0] GCS_RD_NONE = 8'h00;

	// ----------------------------------------
	// channel counts and word layout
	// ----------------------------------------
	localparam int GCS_RX_CHANNELS = 8;
	localparam int GCS_TX_CHANNELS = 4;
	localparam int GCS_WORD_W = 32;
	localparam int GCS_LABEL_W = 8;

	typedef logic [GCS_WORD_W-1:0] gcs_word_type;
	typedef logic [GCS_RX_CHANNELS-1:0] gcs_rx_mask_type;
	typedef logic [GCS_TX_CHANNELS-1:0] gcs_tx_mask_type;

endpackage

// ===== src/gcs_label_flip.sv
// gcs_label_flip: optional bit reversal of the label byte of a word.
// assumes the label sits in the low byte; purely combinational.
`timescale 1ns/10ps
`default_nettype none

module gcs_label_flip (
	input wire logic flip_i,
	input wire gcs_pkg::gcs_word_type word_i,
	output logic [gcs_pkg::GCS_WORD_W-1:0] word_o
);
	import gcs_pkg::*;

	logic [GCS_LABEL_W-1:0] rev;

	// ----------------------------------------
	// per-bit reversal
	// ----------------------------------------
	genvar b;
	generate
		for (b = 0; b < GCS_LABEL_W; b = b + 1) begin : g_rev
			assign rev[b] = word_i[GCS_LABEL_W-1-b];
		end
	endgenerate

	always_comb begin
		word_o = word_i;
		if (flip_i) begin
			word_o[GCS_LABEL_W-1:0] = rev;
		end
	end

endmodule // gcs_label_flip

`default_nettype wire

// ===== src/gcs_global_regs.sv
// gcs_global_regs: global control and status registers with rx/tx gating.
// assumes one clock, async active-high reset, memory-style byte accesses.
`timescale 1ns/10ps
`default_nettype none

module gcs_global_regs (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic ce_i,
	input wire logic [15:0] mem_addr_i,
	input wire logic mem_wr_i,
	input wire logic mem_rd_i,
	input wire logic [7:0] mem_wdata_i,
	output logic [7:0] mem_rdata_o,
	output logic mem_rvalid_o,
	input wire logic host_ready_i,
	input wire logic run_i,
	input wire logic bist_fail_i,
	input wire logic load_fail_i,
	input wire logic ram_check_in_progress_i,
	input wire logic eeprom_write_in_progress_i,
	input wire logic config_load_in_progress_i,
	output logic ready_o,
	input wire logic rx_valid_i,
	input wire logic [2:0] rx_chan_i,
	input wire gcs_pkg::gcs_word_type rx_word_i,
	input wire gcs_pkg::gcs_rx_mask_type rx_chan_en_i,
	output logic rx_store_o,
	output logic [2:0] rx_chan_o,
	output logic [gcs_pkg::GCS_WORD_W-1:0] rx_word_o,
	input wire logic tx_valid_i,
	input wire logic [1:0] tx_chan_i,
	input wire gcs_pkg::gcs_word_type tx_word_i,
	output logic [gcs_pkg::GCS_TX_CHANNELS-1:0] tx_line_valid_o,
	output logic [gcs_pkg::GCS_WORD_W-1:0] tx_word_o,
	output logic [gcs_pkg::GCS_TX_CHANNELS-1:0] tx_seq_rst_o,
	output logic receive_global_enable_o,
	output logic transmit_global_enable_o,
	output logic label_bit_reverse_o
);
	import gcs_pkg::*;

	// ----------------------------------------
	// register access
	// ----------------------------------------
	logic [7:0] ctrl_q, ctrl_d, stat_q, stat_d, rdata_q, rdata_d;
	logic rvalid_q, rvalid_d, ready_q, ready_d;
	logic cfg_hit, hit_ctrl, hit_stat;

	assign cfg_hit = mem_addr_i[GCS_CFG_SEL_BIT];
	assign hit_ctrl = cfg_hit && (mem_addr_i == GCS_CONTROL_ADDR);
	assign hit_stat = cfg_hit && (mem_addr_i == GCS_STATUS_ADDR);

	always_comb begin
		ctrl_d = ctrl_q;
		rdata_d = rdata_q;
		rvalid_d = 1'b0;
		if (mem_wr_i && hit_ctrl) begin
			ctrl_d = mem_wdata_i;
		end
		if (mem_rd_i) begin
			rvalid_d = 1'b1;
			if (hit_stat) begin
				rdata_d = stat_q;
			end else if (hit_ctrl) begin
				rdata_d = ctrl_q;
			end else begin
				rdata_d = GCS_RD_NONE;
			end
		end
	end

	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ctrl_q <= GCS_CTL_RESET;
			rdata_q <= GCS_RD_NONE;
			rvalid_q <= 1'b0;
		end else if (ce_i) begin
			ctrl_q <= ctrl_d;
			rdata_q <= rdata_d;
			rvalid_q <= rvalid_d;
		end
	end

	// ----------------------------------------
	// operational status
	// ----------------------------------------
	always_comb begin
		stat_d = GCS_ST_RESET;
		ready_d = host_ready_i && !eeprom_write_in_progress_i;
		stat_d[GCS_ST_READY] = ready_d;
		stat_d[GCS_ST_SAFE] = stat_q[GCS_ST_SAFE] || bist_fail_i || load_fail_i;
		stat_d[GCS_ST_ACTIVE] = run_i && !stat_d[GCS_ST_SAFE];
		stat_d[GCS_ST_RAM] = ram_check_in_progress_i;
		stat_d[GCS_ST_EEPROM_WRITE_IN_PROGRESS] = eeprom_write_in_progress_i;
		stat_d[GCS_ST_LOAD] = config_load_in_progress_i;
	end

	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			stat_q <= GCS_ST_RESET;
			ready_q <= 1'b0;
		end else if (ce_i) begin
			stat_q <= stat_d;
			ready_q <= ready_d;
		end
	end

	// ----------------------------------------
	// receive and transmit gating
	// ----------------------------------------
	logic [GCS_WORD_W-1:0] rx_flip, tx_flip, rxw_q, rxw_d, txw_q, txw_d;
	logic rxs_q, rxs_d;
	logic [2:0] rxc_q, rxc_d;
	logic [GCS_TX_CHANNELS-1:0] txv_q, txv_d, txr_q, txr_d;

	gcs_label_flip u_rx_flip (
		.flip_i(ctrl_q[GCS_CTL_LBL_REV]),
		.word_i(rx_word_i),
		.word_o(rx_flip)
	);

	gcs_label_flip u_tx_flip (
		.flip_i(ctrl_q[GCS_CTL_LBL_REV]),
		.word_i(tx_word_i),
		.word_o(tx_flip)
	);

	genvar c;
	generate
		for (c = 0; c < GCS_TX_CHANNELS; c = c + 1) begin : g_tx
			assign txv_d[c] = ctrl_q[GCS_CTL_TX_EN] && tx_valid_i && (tx_chan_i == 2'(c));
			assign txr_d[c] = !ctrl_q[GCS_CTL_TX_EN];
		end
	endgenerate

	always_comb begin
		rxs_d = ctrl_q[GCS_CTL_RX_EN] && rx_valid_i && rx_chan_en_i[rx_chan_i];
		rxc_d = rxs_d ? rx_chan_i : rxc_q;
		rxw_d = rxs_d ? rx_flip : rxw_q;
		txw_d = (|txv_d) ? tx_flip : txw_q;
	end

	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rxs_q <= 1'b0;
			rxc_q <= 3'h0;
			rxw_q <= '0;
			txw_q <= '0;
			txv_q <= '0;
			txr_q <= '1;
		end else if (ce_i) begin
			rxs_q <= rxs_d;
			rxc_q <= rxc_d;
			rxw_q <= rxw_d;
			txw_q <= txw_d;
			txv_q <= txv_d;
			txr_q <= txr_d;
		end
	end

	assign mem_rdata_o = rdata_q;
	assign mem_rvalid_o = rvalid_q;
	assign ready_o = ready_q;
	assign rx_store_o = rxs_q;
	assign rx_chan_o = rxc_q;
	assign rx_word_o = rxw_q;
	assign tx_line_valid_o = txv_q;
	assign tx_word_o = txw_q;
	assign tx_seq_rst_o = txr_q;
	assign receive_global_enable_o = ctrl_q[GCS_CTL_RX_EN];
	assign transmit_global_enable_o = ctrl_q[GCS_CTL_TX_EN];
	assign label_bit_reverse_o = ctrl_q[GCS_CTL_LBL_REV];

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);

	rx_gate_a: assert property ($past(ce_i) && rx_store_o |->
		$past(ctrl_q[GCS_CTL_RX_EN]))
		else $error("receive word taken while receive disabled");
	tx_gate_a: assert property ($past(ce_i) && (|tx_line_valid_o) |->
		$past(ctrl_q[GCS_CTL_TX_EN]))
		else $error("transmit word sent while transmit disabled");
	tx_seq_rst_a: assert property (ce_i && !ctrl_q[GCS_CTL_TX_EN] |=>
		tx_seq_rst_o == 4'hf)
		else $error("sequencers not held in reset");
	label_rev_a: assert property (ce_i && rxs_d && ctrl_q[GCS_CTL_LBL_REV] |=>
		rx_word_o[0] == $past(rx_word_i[7]) && rx_word_o[7] == $past(rx_word_i[0]))
		else $error("label byte not reversed");
	ready_mirror_a: assert property (stat_q[GCS_ST_READY] == ready_o &&
		(!$past(ce_i) || $past(sys_rst_i) ||
		ready_o == $past(host_ready_i && !eeprom_write_in_progress_i)))
		else $error("status ready differs from ready output");
	active_run_a: assert property (ce_i && run_i && !stat_q[GCS_ST_SAFE] &&
		!bist_fail_i && !load_fail_i |=> stat_q[GCS_ST_ACTIVE])
		else $error("active not set after run");
	safe_sticky_a: assert property (ce_i && (bist_fail_i || load_fail_i) |=>
		stat_q[GCS_ST_SAFE] ##1 stat_q[GCS_ST_SAFE])
		else $error("safe flag not set or lost");
	ram_busy_a: assert property (ce_i |=>
		stat_q[GCS_ST_RAM] == $past(ram_check_in_progress_i))
		else $error("ram check flag wrong");
	eeprom_write_in_progress_flag_a: assert property (ce_i |=>
		stat_q[GCS_ST_EEPROM_WRITE_IN_PROGRESS] == $past(eeprom_write_in_progress_i))
		else $error("programming flag wrong");
	eeprom_write_in_progress_ready_a: assert property (stat_q[GCS_ST_EEPROM_WRITE_IN_PROGRESS] |-> !ready_o)
		else $error("ready high during programming");
	load_flag_a: assert property (ce_i |=>
		stat_q[GCS_ST_LOAD] == $past(config_load_in_progress_i))
		else $error("load flag wrong");
	stat_read_a: assert property (ce_i && mem_rd_i && hit_stat |=>
		mem_rdata_o == $past(stat_q) && mem_rvalid_o && ctrl_q == $past(ctrl_q))
		else $error("status read wrong or disturbed state");
	unused_zero_a: assert property (stat_q[1:0] == 2'h0)
		else $error("unused status bits not zero");

	rx_store_c: cover property (rx_store_o && label_bit_reverse_o);
	tx_send_c: cover property (|tx_line_valid_o);
	eeprom_write_in_progress_end_c: cover property (stat_q[3] ##1 !stat_q[3] ##[1:4] ready_o);
	safe_c: cover property ($rose(stat_q[5]));

endmodule // gcs_global_regs

`default_nettype wire

// ===== tb/gcs_host_model.sv
// gcs_host_model: host cpu side of the byte register bus.
// assumes the bench calls its tasks; drives just after the falling clock edge.
`timescale 1ns/10ps
`default_nettype none

module gcs_host_model (
	input wire logic clk_i,
	input wire logic rvalid_i,
	input wire logic [7:0] rdata_i,
	output logic [15:0] addr_o,
	output logic wr_o,
	output logic rd_o,
	output logic [7:0] wdata_o
);
	initial begin
		addr_o = 16'h0000;
		wr_o = 1'b0;
		rd_o = 1'b0;
		wdata_o = 8'h00;
	end

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge clk_i);
		addr_o = a;
		wdata_o = d & 8'hc8;
		wr_o = 1'b1;
		@(negedge clk_i);
		wr_o = 1'b0;
		wdata_o = ~wdata_o;
	endtask

	task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic ok);
		@(negedge clk_i);
		addr_o = a;
		rd_o = 1'b1;
		@(negedge clk_i);
		ok = rvalid_i;
		d = rdata_i;
		rd_o = 1'b0;
		addr_o = ~a;
	endtask
endmodule // gcs_host_model

`default_nettype wire

// ===== tb/tb_top.sv
// tb_top: random and corner tests of the global control and status pair.
// assumes gcs_pkg and gcs_global_regs compiled first; 100 mhz clock.
`timescale 1ns/10ps
`default_nettype none

module tb_top;
	import gcs_pkg::*;
	logic sys_clk_i, sys_rst_i, wr, rd, rvalid, ok, ready, run, bist, lfail, hrdy, ram, eeprom_write_in_progress, load;
	logic rx_valid, rx_store, tx_valid, rxg, txg, lbr, ce;
	logic [15:0] addr;
	logic [7:0] wdata, rdata, d, cm;
	logic [2:0] rx_chan, rx_chan_q;
	logic [1:0] tx_chan;
	logic [3:0] tx_line, seq_rst;
	gcs_word_type rx_word, tx_word, w, r;
	gcs_rx_mask_type rx_en;
	logic [31:0] rx_word_q, tx_word_q;
	integer seed = 32'haf5479c7;
	int bad_count = 0;
	int checked = 0;
	int i;

	gcs_host_model host_u (.clk_i(sys_clk_i), .rvalid_i(rvalid), .rdata_i(rdata),
		.addr_o(addr), .wr_o(wr), .rd_o(rd), .wdata_o(wdata));

	gcs_global_regs dut_u (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce),
		.mem_addr_i(addr), .mem_wr_i(wr), .mem_rd_i(rd), .mem_wdata_i(wdata),
		.mem_rdata_o(rdata), .mem_rvalid_o(rvalid), .host_ready_i(hrdy), .run_i(run),
		.bist_fail_i(bist), .load_fail_i(lfail), .ram_check_in_progress_i(ram),
		.eeprom_write_in_progress_i(eeprom_write_in_progress), .config_load_in_progress_i(load), .ready_o(ready),
		.rx_valid_i(rx_valid), .rx_chan_i(rx_chan), .rx_word_i(rx_word), .rx_chan_en_i(rx_en),
		.rx_store_o(rx_store), .rx_chan_o(rx_chan_q), .rx_word_o(rx_word_q),
		.tx_valid_i(tx_valid), .tx_chan_i(tx_chan), .tx_word_i(tx_word),
		.tx_line_valid_o(tx_line), .tx_word_o(tx_word_q), .tx_seq_rst_o(seq_rst),
		.receive_global_enable_o(rxg), .transmit_global_enable_o(txg), .label_bit_reverse_o(lbr));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] flip(input logic [31:0] x, input logic f);
		logic [31:0] y;
		y = x;
		for (int k = 0; k < 8; k++) y[k] = f ? x[7-k] : x[k];
		return y;
	endfunction

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic do_reset();
		sys_rst_i = 1'b1;
		repeat (4) @(negedge sys_clk_i);
		sys_rst_i = 1'b0;
	endtask

	task automatic close_out();
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	initial begin
		sys_clk_i = 1'b0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end

	initial begin
		#100000;
		bad_count++;
		close_out();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{run, bist, lfail, hrdy, ram, eeprom_write_in_progress, load, rx_valid, tx_valid} = '0;
		{rx_chan, tx_chan, rx_word, tx_word, rx_en} = '0;
		ce = 1'b1;
		do_reset();
		chk("seq_rst", 4'hf, seq_rst);
		host_u.rd(GCS_CONTROL_ADDR, d, ok);
		chk("control", 8'h00, d);
		host_u.rd(GCS_STATUS_ADDR, d, ok);
		chk("status", 8'h00, d);
		for (i = 0; i < 30; i++) begin
			r = (i == 0) ? 32'h12 : $random(seed);
			{hrdy, run, ram, eeprom_write_in_progress, load} = r[4:0];
			host_u.rd(GCS_STATUS_ADDR, d, ok);
			chk("rvalid", 1'b1, ok);
			chk("status", {r[4] & ~r[1], r[3], 1'b0, r[2], r[1], r[0], 2'b00}, d);
			chk("ready", r[4] & ~r[1], ready);
		end
		for (i = 0; i < 40; i++) begin
			w = $random(seed);
			host_u.wr(GCS_CONTROL_ADDR, w[31:24]);
			cm = w[31:24] & 8'hc8;
			{rx_chan, rx_en, rx_word, tx_chan, tx_word} = {w[2:0], w[15:8], w, w[5:4], ~w};
			{rx_valid, tx_valid} = 2'b11;
			@(negedge sys_clk_i);
			{rx_valid, tx_valid} = 2'b00;
			chk("enables", {cm[7], cm[6], cm[3]}, {rxg, txg, lbr});
			chk("seq_rst", cm[6] ? 4'h0 : 4'hf, seq_rst);
			chk("rx_store", cm[7] & rx_en[rx_chan], rx_store);
			if (cm[7] & rx_en[rx_chan]) chk("rx_word", flip(w, cm[3]), rx_word_q);
			if (cm[7] & rx_en[rx_chan]) chk("rx_chan", rx_chan, rx_chan_q);
			chk("tx_line", cm[6] ? (4'h1 << tx_chan) : 4'h0, tx_line);
			if (cm[6]) chk("tx_word", flip(~w, cm[3]), tx_word_q);
			host_u.rd(GCS_CONTROL_ADDR, d, ok);
			chk("control", cm, d);
		end
		host_u.wr(16'h000f, 8'hff);
		host_u.wr(GCS_STATUS_ADDR, 8'hff);
		host_u.rd(GCS_CONTROL_ADDR, d, ok);
		chk("control", cm, d);
		host_u.rd(16'h800d, d, ok);
		chk("unmapped", 8'h00, d);
		host_u.rd(16'h000e, d, ok);
		chk("low_addr", 8'h00, d);
		// write while frozen must not land
		ce = 1'b0;
		host_u.wr(GCS_CONTROL_ADDR, ~cm);
		chk("frozen", {cm[7], cm[6], cm[3]}, {rxg, txg, lbr});
		ce = 1'b1;
		host_u.rd(GCS_CONTROL_ADDR, d, ok);
		chk("thawed", cm, d);
		for (i = 0; i < 2; i++) begin
			{run, hrdy, ram, eeprom_write_in_progress, load, bist, lfail} = {5'b10000, i == 0, i == 1};
			@(negedge sys_clk_i);
			{bist, lfail} = 2'b00;
			host_u.rd(GCS_STATUS_ADDR, d, ok);
			chk("safe", 8'h20, d);
			host_u.rd(GCS_STATUS_ADDR, d, ok);
			chk("safe_held", 8'h20, d);
			do_reset();
			host_u.rd(GCS_STATUS_ADDR, d, ok);
			chk("after_reset", 8'h40, d);
		end
		close_out();
	end
endmodule // tb_top

`default_nettype wire
